// ==== pkg/rss_defs.svh ====
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define RSS_CLK_HZ 40000000
`define RSS_NUM_CH 16
`define RSS_CH_W 4
// read strobe indicator hold time
`define RSS_STROBE_TIME_MS 1000
`define RSS_STROBE_CYC ((`RSS_CLK_HZ / 1000) * `RSS_STROBE_TIME_MS)
// self-trigger period, no rate is fixed for it
`define RSS_SELF_TRIG_MS 1000
`define RSS_SELF_TRIG_CYC ((`RSS_CLK_HZ / 1000) * `RSS_SELF_TRIG_MS)
// one channel slot of the serial scan
`define RSS_SLOT_TIME_US 100
`define RSS_SLOT_CYC ((`RSS_CLK_HZ / 1000000) * `RSS_SLOT_TIME_US)

// ****************************************************************
// reset values
// ****************************************************************
`define RSS_CH_RST 4'h0
`define RSS_LOG_RST 16'h0000
`define RSS_CNT_RST 32'h00000000

`endif

// ==== pkg/rss_pkg.sv ====
`include "rss_defs.svh"

package rss_pkg;

   typedef enum logic [1:0] {
      RSS_IDLE = 2'b01,
      RSS_SCAN = 2'b10
   } rss_scan_st_t;

   typedef logic [`RSS_CH_W-1:0] rss_ch_t;

   typedef struct packed {
      rss_scan_st_t st;
      rss_ch_t slot;
      logic [31:0] slot_cnt;
      logic [31:0] self_cnt;
      logic [31:0] strobe_cnt;
      rss_ch_t samp_ptr;
      rss_ch_t samp_ch;
      logic [`RSS_NUM_CH-1:0] logger_en;
      logic rd_led;
      logic act;
      logic smp;
      logic trig_g;
      logic trig_r;
      logic pwr_g;
      logic pwr_r;
      rss_ch_t front_sel;
   } rss_state_t;

   typedef struct packed {
      logic [6:0] s1;
      logic [6:0] s2;
      logic ext_prev;
      rss_ch_t sel_prev;
      rss_ch_t sel_hold;
   } rss_sync_state_t;

endpackage : rss_pkg

// ==== pkg/rss_pin_if.sv ====
interface rss_pin_if;
   import rss_pkg::*;
   logic ext_mode;
   logic ext_rise;
   logic pwr_ok;
   rss_ch_t front_sel;

   modport src (
      output ext_mode,
      output ext_rise,
      output pwr_ok,
      output front_sel
   );
   modport snk (
      input ext_mode,
      input ext_rise,
      input pwr_ok,
      input front_sel
   );
endinterface : rss_pin_if

// ==== design/rss_sync.sv ====
`include "rss_defs.svh"

module rss_sync (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic trig_mode_ext_i,
   input wire logic ext_trig_i,
   input wire logic power_good_i,
   input wire rss_pkg::rss_ch_t front_sel_i,
   rss_pin_if.src pins
);
   import rss_pkg::*;

   rss_sync_state_t q, d;

   // s1 feeds s2 only; everything else looks at s2
   always_comb begin
      d = q;
      d.s1 = {front_sel_i, power_good_i, ext_trig_i, trig_mode_ext_i};
      d.s2 = q.s1;
      d.ext_prev = q.s2[1];
      d.sel_prev = q.s2[6:3];
      // selector word taken only once two synced samples agree, so bits
      // settling on different edges never show a false channel
      if (q.s2[6:3] == q.sel_prev) begin
         d.sel_hold = q.sel_prev;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pins.ext_mode = q.s2[0];
   assign pins.ext_rise = q.s2[1] & ~q.ext_prev;
   assign pins.pwr_ok = q.s2[2];
   assign pins.front_sel = q.sel_hold;

   a_rise_single: assert property (
      @(posedge mclk_i) disable iff (srst_i)
      pins.ext_rise |=> !pins.ext_rise
   ) else $error("external trigger edge lasted more than one cycle");

endmodule : rss_sync

// ==== design/rss_scan_top.sv ====
`include "rss_defs.svh"

module rss_scan_top #(
   parameter int unsigned STROBE_CYC = `RSS_STROBE_CYC,
   parameter int unsigned SELF_TRIG_CYC = `RSS_SELF_TRIG_CYC,
   parameter int unsigned SLOT_CYC = `RSS_SLOT_CYC
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic trig_mode_ext_i,
   input wire logic ext_trig_i,
   input wire logic power_good_i,
   input wire rss_pkg::rss_ch_t front_sel_i,
   output logic trig_led_green_o,
   output logic trig_led_red_o,
   output logic read_strobe_led_o,
   output logic power_led_green_o,
   output logic power_led_red_o,
   output rss_pkg::rss_ch_t readout_disp_o,
   output rss_pkg::rss_ch_t serial_disp_o,
   output rss_pkg::rss_ch_t serial_analog_out_sel_o,
   output logic serial_active_flag_o,
   output logic slot_sample_strobe_o,
   output rss_pkg::rss_ch_t front_analog_out_sel_o,
   output rss_pkg::rss_ch_t front_disp_o,
   output logic [`RSS_NUM_CH-1:0] logger_en_o
);
   import rss_pkg::*;

   localparam int SCAN_CYC = `RSS_NUM_CH * SLOT_CYC;

   rss_pin_if pins ();
   rss_state_t q, d;
   logic self_fire;
   logic trig;

   rss_sync u_sync (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .trig_mode_ext_i(trig_mode_ext_i),
      .ext_trig_i(ext_trig_i),
      .power_good_i(power_good_i),
      .front_sel_i(front_sel_i),
      .pins(pins)
   );

   // one-hot logger line for a channel index
   function automatic logic [`RSS_NUM_CH-1:0] ch_onehot(input rss_ch_t ch);
      ch_onehot = '0;
      ch_onehot[ch] = 1'b1;
   endfunction : ch_onehot

   // ****************************************************************
   // trigger selection
   // ****************************************************************
   assign self_fire = !pins.ext_mode && (q.self_cnt == 32'(SELF_TRIG_CYC - 1));
   assign trig = pins.ext_mode ? pins.ext_rise : self_fire;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      d = q;
      // self counter idles in external mode so a mode flip starts clean
      if (pins.ext_mode || self_fire) begin
         d.self_cnt = `RSS_CNT_RST;
      end else begin
         d.self_cnt = q.self_cnt + 32'h00000001;
      end

      d.trig_g = !pins.ext_mode;
      d.trig_r = pins.ext_mode;
      d.pwr_g = pins.pwr_ok;
      d.pwr_r = !pins.pwr_ok;
      d.front_sel = pins.front_sel;

      // retrigger reloads, so fast triggers keep the led lit
      if (trig) begin
         d.strobe_cnt = 32'(STROBE_CYC);
         d.rd_led = 1'b1;
      end else if (q.strobe_cnt != `RSS_CNT_RST) begin
         d.strobe_cnt = q.strobe_cnt - 32'h00000001;
         if (q.strobe_cnt == 32'h00000001) begin
            d.rd_led = 1'b0;
         end
      end

      // sampling pointer steps one channel per trigger
      if (trig) begin
         d.samp_ch = q.samp_ptr;
         d.logger_en = ch_onehot(q.samp_ptr);
         d.samp_ptr = q.samp_ptr + 4'h1;
      end

      d.smp = 1'b0;
      unique case (q.st)
         RSS_IDLE: begin
            // a trigger while scanning is absorbed by the running scan
            if (trig) begin
               d.st = RSS_SCAN;
               d.slot = `RSS_CH_RST;
               d.slot_cnt = `RSS_CNT_RST;
               d.act = 1'b1;
            end
         end
         RSS_SCAN: begin
            d.slot_cnt = q.slot_cnt + 32'h00000001;
            if (q.slot_cnt == 32'(SLOT_CYC / 2)) begin
               d.smp = 1'b1;
            end
            if (q.slot_cnt == 32'(SLOT_CYC - 1)) begin
               d.slot_cnt = `RSS_CNT_RST;
               if (q.slot == 4'hF) begin
                  d.st = RSS_IDLE;
                  d.act = 1'b0;
               end else begin
                  d.slot = q.slot + 4'h1;
               end
            end
         end
         default: begin
            d.st = RSS_IDLE;
            d.act = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         q <= '{st: RSS_IDLE, slot: `RSS_CH_RST, slot_cnt: `RSS_CNT_RST,
                self_cnt: `RSS_CNT_RST, strobe_cnt: `RSS_CNT_RST,
                samp_ptr: `RSS_CH_RST, samp_ch: `RSS_CH_RST,
                logger_en: `RSS_LOG_RST, rd_led: 1'b0, act: 1'b0,
                smp: 1'b0, trig_g: 1'b1, trig_r: 1'b0, pwr_g: 1'b0,
                pwr_r: 1'b1, front_sel: `RSS_CH_RST};
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // outputs, all straight from state flops
   // ****************************************************************
   assign trig_led_green_o = q.trig_g;
   assign trig_led_red_o = q.trig_r;
   assign read_strobe_led_o = q.rd_led;
   assign power_led_green_o = q.pwr_g;
   assign power_led_red_o = q.pwr_r;
   assign readout_disp_o = q.samp_ch;
   assign serial_disp_o = q.slot;
   assign serial_analog_out_sel_o = q.slot;
   assign serial_active_flag_o = q.act;
   assign slot_sample_strobe_o = q.smp;
   assign front_analog_out_sel_o = q.front_sel;
   assign front_disp_o = q.front_sel;
   assign logger_en_o = q.logger_en;

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [31:0] act_run;
   always_ff @(posedge mclk_i) begin
      if (srst_i || !q.act) begin
         act_run <= `RSS_CNT_RST;
      end else begin
         act_run <= act_run + 32'h00000001;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   sequence s_ext_ignored;
      !pins.ext_mode && pins.ext_rise && !self_fire;
   endsequence
   sequence s_scan_start;
      trig && q.st == RSS_IDLE;
   endsequence

   a_ext_mode_gate: assert property (
      s_ext_ignored |=> q.samp_ptr == $past(q.samp_ptr)
   ) else $error("external edge acted in internal mode");

   a_src_led: assert property (
      ##1 (trig_led_red_o == $past(pins.ext_mode))
          && (trig_led_green_o != trig_led_red_o)
   ) else $error("trigger source led wrong");

   a_readout_code: assert property (
      trig |=> readout_disp_o == $past(q.samp_ptr)
   ) else $error("readout display not the sampled channel");

   a_serial_disp: assert property (
      (serial_active_flag_o && q.slot_cnt != 32'(SLOT_CYC - 1))
      |=> $stable(serial_disp_o)
          && serial_disp_o == serial_analog_out_sel_o
   ) else $error("serial display wrong inside a slot");

   a_strobe_hold: assert property (
      trig |=> read_strobe_led_o [*8]
   ) else $error("read strobe led dropped early");

   a_scan_bound: assert property (
      act_run <= 32'(SCAN_CYC)
   ) else $error("scan longer than sixteen slots");

   a_scan_full: assert property (
      $fell(serial_active_flag_o) |-> $past(act_run) == 32'(SCAN_CYC - 1)
   ) else $error("scan did not cover all sixteen slots");

   a_scan_order: assert property (
      (serial_active_flag_o && $changed(serial_analog_out_sel_o))
      |-> serial_analog_out_sel_o == $past(serial_analog_out_sel_o) + 4'h1
   ) else $error("serial channels out of order");

   a_active_start: assert property (
      s_scan_start |=> serial_active_flag_o && serial_analog_out_sel_o == 4'h0
   ) else $error("scan did not start at first channel");

   a_smp_pulse: assert property (
      slot_sample_strobe_o |-> serial_active_flag_o ##1 !slot_sample_strobe_o
   ) else $error("sample strobe outside scan or too long");

   a_pwr_led: assert property (
      ##1 (power_led_green_o == $past(pins.pwr_ok))
          && (power_led_red_o == !power_led_green_o)
   ) else $error("power led wrong");

   a_front_follow: assert property (
      $changed(pins.front_sel) |=> front_analog_out_sel_o == $past(pins.front_sel)
   ) else $error("front channel did not follow selector");

   a_logger_one: assert property (
      trig |=> $onehot(logger_en_o) && logger_en_o[$past(q.samp_ptr)]
   ) else $error("logger line not the sampled channel");

endmodule : rss_scan_top

// ==== testbench/rss_adc_model.sv ====
module rss_adc_model (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic active_i,
   input wire logic strobe_i,
   input wire rss_pkg::rss_ch_t sel_i,
   output logic [7:0] conv_cnt_o,
   output logic order_bad_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import rss_pkg::*;
   logic act_q;
   // converter counts conversions per scan and flags any slot out of order
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         act_q <= 1'b0;
         conv_cnt_o <= 8'h00;
         order_bad_o <= 1'b0;
      end else begin
         act_q <= active_i;
         if (active_i && !act_q) begin
            conv_cnt_o <= 8'h00;
         end
         if (strobe_i) begin
            // sticky: one stray strobe anywhere fails the run
            if (!active_i || sel_i !== conv_cnt_o[3:0]) begin
               order_bad_o <= 1'b1;
            end
            conv_cnt_o <= conv_cnt_o + 8'h01;
         end
      end
   end
endmodule : rss_adc_model

// ==== testbench/tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rss_pkg::*;
   localparam int SLOT = 8;
   localparam int STRB = 50;
   localparam int SELF = 300;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic trig_mode_ext_i = 1'b1;
   logic ext_trig_i = 1'b0;
   logic power_good_i = 1'b0;
   rss_ch_t front_sel_i = 4'h0;
   logic trig_g, trig_r, rd_led, pwr_g, pwr_r, flag, smp;
   rss_ch_t readout, sdisp, ssel, fsel, fdisp, exp_ptr;
   logic [15:0] logger;
   logic [7:0] conv_cnt;
   logic order_bad;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int seed = 32'h1aaa;
   int n;
   rss_scan_top #(.STROBE_CYC(STRB), .SELF_TRIG_CYC(SELF),
      .SLOT_CYC(SLOT)) rss_scan_top_inst (
      .mclk_i(mclk_i), .srst_i(srst_i), .trig_mode_ext_i(trig_mode_ext_i),
      .ext_trig_i(ext_trig_i), .power_good_i(power_good_i),
      .front_sel_i(front_sel_i), .trig_led_green_o(trig_g),
      .trig_led_red_o(trig_r), .read_strobe_led_o(rd_led),
      .power_led_green_o(pwr_g), .power_led_red_o(pwr_r),
      .readout_disp_o(readout), .serial_disp_o(sdisp),
      .serial_analog_out_sel_o(ssel), .serial_active_flag_o(flag),
      .slot_sample_strobe_o(smp), .front_analog_out_sel_o(fsel),
      .front_disp_o(fdisp), .logger_en_o(logger));
   rss_adc_model rss_adc_model_inst (
      .mclk_i(mclk_i), .srst_i(srst_i), .active_i(flag), .strobe_i(smp),
      .sel_i(ssel), .conv_cnt_o(conv_cnt), .order_bad_o(order_bad));
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end
   // ****************************************************************
   // checking and closing
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
      #2;
   endtask : tick
   // ****************************************************************
   // one scan: np extra external pulses, pointer expected to move adv
   // ****************************************************************
   task automatic run_scan(input int np, input int adv);
      int i, w, flag_n, led_n;
      rss_ch_t last;
      flag_n = 0;
      led_n = 0;
      for (w = 0; w < 400 && trig_mode_ext_i === 1'b0
           && flag !== 1'b1; w++) begin
         tick(1);
      end
      for (i = 0; i < 200; i++) begin
         // pin pulses two high, two low: always a synced low between
         ext_trig_i = (trig_mode_ext_i && i < 2) ||
            (i >= 10 && i < 10 + 4 * np && (i - 10) % 4 < 2);
         check(sdisp, ssel);
         if (flag === 1'b1) begin
            check(ssel, rss_ch_t'(flag_n / SLOT));
         end
         flag_n += (flag === 1'b1);
         led_n += (rd_led === 1'b1);
         tick(1);
      end
      check(flag_n, 16 * SLOT);
      check(conv_cnt, 16);
      check(order_bad, 1'b0);
      if (adv == 1) begin
         check(led_n, STRB);
      end
      exp_ptr = exp_ptr + rss_ch_t'(adv);
      last = exp_ptr - 4'h1;
      check(readout, last);
      check(logger, 16'h0001 << last);
   endtask : run_scan
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      exp_ptr = 4'h0;
      tick(2);
      check({trig_g, trig_r, pwr_g, pwr_r}, 4'h9);
      check(logger, 16'h0000);
      tick(3);
      srst_i = 1'b0;
      tick(4);
      check({trig_g, trig_r}, 2'b01);
      power_good_i = 1'b1;
      tick(4);
      check({pwr_g, pwr_r}, 2'b10);
      power_good_i = 1'b0;
      tick(4);
      check({pwr_g, pwr_r}, 2'b01);
      for (int k = 0; k < 8; k++) begin
         front_sel_i = (k == 0) ? 4'hF : rss_ch_t'($random(seed));
         tick(6);
         check(fsel, front_sel_i);
         check(fdisp, front_sel_i);
      end
      run_scan(0, 1);
      run_scan(3, 4);
      n = {$random(seed)} % 4;
      run_scan(n, n + 1);
      trig_mode_ext_i = 1'b0;
      tick(4);
      check({trig_g, trig_r}, 2'b10);
      // external pulses must not count in internal mode
      run_scan(2, 1);
      trig_mode_ext_i = 1'b1;
      tick(4);
      // walk the pointer through the wrap from F back to 0
      for (int k = 0; k < 4; k++) begin
         run_scan(3, 4);
      end
      report_and_stop();
   end
endmodule : tb
